// ==== src/spw_soft_power.v ====
// Standby soft power controller: power state, wake sources, button
// debounce and override timer, configuration registers, SCI/SMI routing.
// Assumes inputs other than rst_n, button_in and wake_n synchronous to clk and tick_32k a one-cycle strobe
// at the standby clock rate; rst_n is the battery power-on reset.
`timescale 1ns/1ps
`default_nettype none
`include "spw_defines.vh"

module spw_soft_power #(
  parameter HALF_SEC_TICKS = `SPW_HALF_SEC_TICKS,
  parameter DEBOUNCE_TICKS = `SPW_DEBOUNCE_TICKS,
  parameter OVR_HALF_SECS  = `SPW_OVR_HALF_SECS
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       tick_32k,
  input  wire       button_in,
  input  wire [9:0] wake_n,
  input  wire       vtr_por,
  input  wire [7:0] cfg_addr,
  input  wire       cfg_wr,
  input  wire       cfg_rd,
  input  wire [7:0] cfg_wdata,
  output reg  [7:0] cfg_rdata,
  input  wire       override_enable,
  input  wire       power_button_enable,
  input  wire       sci_route_enable,
  input  wire       smi_route_enable,
  input  wire       sci_to_pin,
  input  wire       sci_active_high,
  input  wire       sci_push_pull,
  input  wire       override_status_clear,
  input  wire       power_button_status_clear,
  output reg        power_on_n_out,
  output reg        power_on_oe,
  output reg        override_status,
  output reg        power_button_status,
  output reg        sci_pin_out,
  output reg        sci_pin_oe,
  output reg        sci_irq_out,
  output reg        smi_out,
  output reg        restart_count,
  output reg        stop_count
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers

  reg        rst_q1;
  reg        rst_q2;
  wire       rst_int_n = rst_q2;
  reg [10:0] in_meta;
  reg [10:0] in_sync;

  // Reset asserts at once, releases two edges later
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  // Two-stage synchroniser; first stage feeds only the second
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      in_meta <= 11'h3ff;
      in_sync <= 11'h3ff;
    end else if (ce) begin
      in_meta <= {button_in, wake_n};
      in_sync <= in_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Standby-tick sampling and edge detection

  reg  [10:0] samp_cur;
  reg  [10:0] samp_prev;
  reg         edge_valid;

  // Edges are judged only on tick samples so glitches between ticks are lost
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      samp_cur   <= 11'h3ff;
      samp_prev  <= 11'h3ff;
      edge_valid <= 1'b0;
    end else if (ce) begin
      edge_valid <= tick_32k;
      if (tick_32k) begin
        samp_cur  <= in_sync;
        samp_prev <= samp_cur;
      end
    end
  end

  wire [10:0] falls    = edge_valid ? (samp_prev & ~samp_cur) : 11'h000;
  wire        btn_held = samp_cur[10];
  wire        btn_fall = falls[10];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  reg  [7:0] wake_enable_one;
  reg  [7:0] wake_enable_two;
  reg  [7:0] wake_status_one;
  reg  [3:0] wake_status_two;
  reg  [7:0] delay_two_time;
  reg        software_power_off;

  wire wr_en1   = ce & cfg_wr & (cfg_addr == `SPW_ADDR_EN1);
  wire wr_en2   = ce & cfg_wr & (cfg_addr == `SPW_ADDR_EN2);
  wire wr_sts1  = ce & cfg_wr & (cfg_addr == `SPW_ADDR_STS1);
  wire wr_sts2  = ce & cfg_wr & (cfg_addr == `SPW_ADDR_STS2);
  wire wr_dly2  = ce & cfg_wr & (cfg_addr == `SPW_ADDR_DELAY2);
  wire wr_ctrl  = ce & cfg_wr & (cfg_addr == `SPW_ADDR_CTRL);

  // Wake events in enable/status bit order
  wire [7:0] set_one = falls[7:0];
  wire [3:0] set_two = {vtr_por & ce, btn_fall, falls[9], falls[8]};

  // Battery reset is the only reset of the stored configuration
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      wake_enable_one    <= `SPW_EN1_RST;
      wake_enable_two    <= `SPW_EN2_RST;
      delay_two_time     <= `SPW_DELAY2_RST;
      restart_count      <= 1'b0;
      stop_count         <= 1'b0;
      software_power_off <= 1'b0;
      wake_status_one    <= 8'h00;
      wake_status_two    <= 4'h0;
    end else if (ce) begin
      software_power_off <= wr_ctrl & cfg_wdata[`SPW_CTRL_SWOFF];
      if (wr_en1)
        wake_enable_one <= cfg_wdata;
      if (wr_en2)
        wake_enable_two <= {1'b0, cfg_wdata[6:0]};
      if (wr_dly2)
        delay_two_time <= cfg_wdata;
      if (wr_ctrl) begin
        restart_count <= cfg_wdata[`SPW_CTRL_RESTART];
        stop_count    <= cfg_wdata[`SPW_CTRL_STOP];
      end
      // Write one clears; a same-cycle event still sets
      wake_status_one <= (wake_status_one & ~(wr_sts1 ? cfg_wdata : 8'h00)) | set_one;
      wake_status_two <= (wake_status_two & ~(wr_sts2 ? cfg_wdata[3:0] : 4'h0)) | set_two;
    end
  end

  // Read data registered; unmapped offsets read zero
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cfg_rdata <= 8'h00;
    end else if (ce && cfg_rd) begin
      case (cfg_addr)
        `SPW_ADDR_EN1:   cfg_rdata <= wake_enable_one;
        `SPW_ADDR_EN2:   cfg_rdata <= wake_enable_two;
        `SPW_ADDR_STS1:  cfg_rdata <= wake_status_one;
        `SPW_ADDR_STS2:  cfg_rdata <= {4'h0, wake_status_two};
        `SPW_ADDR_DELAY2: cfg_rdata <= delay_two_time;
        `SPW_ADDR_CTRL:  cfg_rdata <= {1'b0, restart_count, stop_count, 5'h00};
        default:         cfg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Override timer

  reg [15:0] ovr_pre;
  reg [3:0]  ovr_halves;
  reg        ovr_fired;
  reg        ovr_blank;
  wire       ovr_pulse = ce & tick_32k & btn_held & ~ovr_fired &
                         (ovr_halves == OVR_HALF_SECS[3:0]);

  // Prescaler restarts with each press, so the fire point is fixed at one tick past 4 s
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ovr_pre    <= 16'h0000;
      ovr_halves <= 4'h0;
      ovr_fired  <= 1'b0;
    end else if (ce && tick_32k) begin
      if (!btn_held) begin
        ovr_pre    <= 16'h0000;
        ovr_halves <= 4'h0;
        ovr_fired  <= 1'b0;
      end else if (ovr_pulse) begin
        ovr_fired <= 1'b1;
      end else if (!ovr_fired) begin
        if (ovr_pre == HALF_SEC_TICKS[15:0] - 16'h0001) begin
          ovr_pre    <= 16'h0000;
          ovr_halves <= ovr_halves + 4'h1;
        end else begin
          ovr_pre <= ovr_pre + 16'h0001;
        end
      end
    end
  end

  wire ovr_event = ovr_pulse & override_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Button debounce for power-off

  reg [15:0] deb_cnt;
  reg        deb_active;
  reg        power_state;
  wire       deb_done = ce & tick_32k & deb_active & ~btn_held &
                        (deb_cnt == DEBOUNCE_TICKS[15:0] - 16'h0001);

  // Release must stay clean for the whole delay before power drops
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      deb_active <= 1'b0;
      deb_cnt    <= 16'h0000;
    end else if (ce) begin
      if (btn_fall && power_state && wake_enable_two[`SPW_EN2_OFF_EN] && !ovr_blank) begin
        deb_active <= 1'b1;
        deb_cnt    <= 16'h0000;
      end else if (deb_active && tick_32k) begin
        if (btn_held || deb_done)
          deb_active <= 1'b0;
        else
          deb_cnt <= deb_cnt + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state flip-flop

  wire wake_on = |(set_one & wake_enable_one) |
                 |(set_two[2:0] & wake_enable_two[2:0]);
  wire off_req = software_power_off | ovr_event |
                 (deb_done & wake_enable_two[`SPW_EN2_OFF_EN]);

  // Off wins over on; battery reset only, so standby loss keeps the state
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      power_state <= 1'b0;
      ovr_blank   <= 1'b0;
    end else if (ce) begin
      if (ovr_event)
        ovr_blank <= 1'b1;
      else if (btn_fall)
        ovr_blank <= 1'b0;
      if (off_req)
        power_state <= 1'b0;
      else if (vtr_por && wake_enable_two[`SPW_EN2_POR_OFF])
        power_state <= 1'b0;
      else if (vtr_por && wake_enable_two[`SPW_EN2_POR_ON])
        power_state <= 1'b1;
      else if (wake_on && !(btn_fall && ovr_blank))
        power_state <= 1'b1;
    end
  end

  // Open drain: low while on, released (floating) while off
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      power_on_n_out <= 1'b1;
      power_on_oe    <= 1'b0;
    end else if (ce) begin
      power_on_n_out <= ~power_state;
      power_on_oe    <= power_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Button status, override status and event routing

  // Override clears button status; each flag keeps set over clear
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      override_status     <= 1'b0;
      power_button_status <= 1'b0;
    end else if (ce) begin
      override_status <= (override_status & ~override_status_clear) | ovr_event;
      if (ovr_event)
        power_button_status <= 1'b0;
      else
        power_button_status <= (power_button_status & ~power_button_status_clear) | btn_fall;
    end
  end

  wire pm_event = (power_button_status & power_button_enable) |
                  (override_status & override_enable);
  wire sci_act  = pm_event & sci_route_enable;
  wire pin_lvl  = sci_active_high ? sci_act : ~sci_act;

  // Both routes may be on together; open collector drives only its low level
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      smi_out     <= 1'b0;
      sci_irq_out <= 1'b0;
      sci_pin_out <= 1'b1;
      sci_pin_oe  <= 1'b0;
    end else if (ce) begin
      smi_out     <= pm_event & smi_route_enable;
      sci_irq_out <= sci_act & ~sci_to_pin;
      sci_pin_out <= pin_lvl;
      sci_pin_oe  <= sci_to_pin & (sci_push_pull | ~pin_lvl);
    end
  end

endmodule // spw_soft_power
`default_nettype wire

// ==== src/spw_defines.vh ====
// Constants for the standby soft power controller: register offsets,
// field positions, reset values and timing counts.
// Assumes a 32768 Hz standby tick strobe alongside the 250 MHz core clock.
//
// What this block does
// - Enabled button or wake fall powers on
// - Power-up bit forces on at standby reset
// - Stay-off bit keeps output floating at reset
// - Button power-off only after debounce delay
// - Button-off enable defaults one, gates button off
// - Control write with bit 7 powers off
// - Control bits 7:5: off, restart, stop
// - Two enable registers select wake sources
// - Status sets always; only enabled events power on
// - Configuration cleared only by battery reset
// - Power state kept through standby loss
// - Delay two spans 500ms to 32s, default 500ms; here the register is only stored and read back, no timer uses it
// - Override timer counts while pressed, clears released
// - Override fires between four and 4.5 seconds
// - Override timer from divided 32k, clears state
// - Override sets status, clears button status, powers off
// - Override status cleared by writing one
// - Control bit 0 routes events to SCI
// - SMI bit 7 routes events to SMI; both allowed
// - SCI steerable, polarity and drive selectable
// - Button press sets status, raises enabled SCI
`ifndef SPW_DEFINES_VH
`define SPW_DEFINES_VH

// Register offsets
`define SPW_ADDR_EN1        8'hb0
`define SPW_ADDR_EN2        8'hb1
`define SPW_ADDR_STS1       8'hb2
`define SPW_ADDR_STS2       8'hb3
`define SPW_ADDR_DELAY2     8'hb8
`define SPW_ADDR_CTRL       8'hf4

// Second enable register fields
`define SPW_EN2_RXD2        0
`define SPW_EN2_RING        1
`define SPW_EN2_BUTTON      2
`define SPW_EN2_VTRPOR      3
`define SPW_EN2_POR_OFF     4
`define SPW_EN2_OFF_EN      5
`define SPW_EN2_POR_ON      6

// Control register fields
`define SPW_CTRL_SWOFF      7
`define SPW_CTRL_RESTART    6
`define SPW_CTRL_STOP       5

// Reset values
`define SPW_EN1_RST         8'h00
`define SPW_EN2_RST         8'h20
`define SPW_DELAY2_RST      8'h00
`define SPW_CTRL_RST        8'h00

// Timing: standby tick rate, debounce and override figures
`define SPW_TICK_HZ         32768
`define SPW_DEBOUNCE_MS     16
`define SPW_DEBOUNCE_TICKS  ((`SPW_DEBOUNCE_MS * `SPW_TICK_HZ + 999) / 1000)
`define SPW_HALF_SEC_TICKS  (`SPW_TICK_HZ / 2)
`define SPW_OVR_HALF_SECS   8

`endif

// ==== testbench/spw_soft_power_properties.sv ====
// Port-level assertion checker for the standby soft power controller.
// Assumes ce gates every request and the bind below attaches it to every instance.
`timescale 1ns/1ps
`default_nettype none
module spw_props (
  input wire       clk, rst_n, ce, cfg_wr, override_enable, power_button_enable,
  input wire [7:0] cfg_addr, cfg_wdata,
  input wire       sci_route_enable, smi_route_enable, sci_to_pin, override_status_clear,
  input wire       power_on_n_out, power_on_oe, override_status, power_button_status,
  input wire       sci_irq_out, smi_out, restart_count, stop_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Event seen by both interrupt routes, and a control write request
  wire pm  = (power_button_status & power_button_enable) | (override_status & override_enable);
  wire f4w = ce & cfg_wr & (cfg_addr == 8'hf4);
  ////////////////////////////////////////////////////////////
  a_pin_floats: assert property (power_on_oe != power_on_n_out)
    else $error("power-on drive and level disagree");
  a_soft_off: assert property (f4w && cfg_wdata[7] |-> ##[1:4] power_on_n_out)
    else $error("software off did not remove power");
  a_ctrl_bits: assert property (f4w |=> restart_count == $past(cfg_wdata[6]) && stop_count == $past(cfg_wdata[5]))
    else $error("control bits not stored");
  a_ovr_off: assert property ($rose(override_status) |-> ##[0:3] (power_on_n_out && !power_button_status))
    else $error("override did not power off");
  a_ovr_gate: assert property ($rose(override_status) |-> $past(override_enable))
    else $error("override flagged while disabled");
  a_ovr_sticky: assert property (override_status && !(ce && override_status_clear) |=> override_status)
    else $error("override flag lost without clear");
  a_smi_route: assert property ($past(ce) |-> smi_out == $past(pm & smi_route_enable))
    else $error("smi output wrong");
  a_sci_irq: assert property ($past(ce) |-> sci_irq_out == $past(pm & sci_route_enable & !sci_to_pin))
    else $error("sci interrupt line wrong");
endmodule // spw_props
bind spw_soft_power spw_props u_props (.*);
`default_nettype wire

// ==== testbench/spw_supply_model.sv ====
// Main supply switched by the active-low power-on pin.
// Assumes a pull-up on the pin, so a floated pin keeps the supply off.
`timescale 1ns/1ps
`default_nettype none
module spw_supply_model #(parameter RAMP = 2) (
  input wire clk,
  input wire power_on_n_out,
  input wire power_on_oe,
  output reg supply_on
);
  wire       pin = power_on_oe ? power_on_n_out : 1'b1;
  reg  [3:0] cnt = 4'h0;
  initial supply_on = 1'b0;
  // Supply ramps up after a short delay, drops at once when released
  always @(posedge clk) begin
    cnt       <= pin ? 4'h0 : (cnt == RAMP ? cnt : cnt + 4'h1);
    supply_on <= !pin && cnt == RAMP;
  end
endmodule // spw_supply_model
`default_nettype wire

// ==== testbench/test_soft_power_wake_override.sv ====
// Self-checking bench for the standby soft power controller.
// Assumes shortened tick counts; inputs change at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module test_soft_power_wake_override;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, tick_32k = 1'b0, button_in = 1'b0, vtr_por = 1'b0;
  logic cfg_wr = 1'b0, cfg_rd = 1'b0, override_enable = 1'b0, power_button_enable = 1'b0;
  logic sci_route_enable = 1'b0, smi_route_enable = 1'b0, sci_to_pin = 1'b0;
  logic sci_active_high = 1'b0, sci_push_pull = 1'b0, override_status_clear = 1'b0, power_button_status_clear = 1'b0;
  logic [9:0] wake_n = 10'h3ff;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, d;
  wire  [7:0] cfg_rdata;
  wire power_on_n_out, power_on_oe, override_status, power_button_status, sci_pin_out, sci_pin_oe;
  wire sci_irq_out, smi_out, restart_count, stop_count, supply_on;
  integer mismatches = 0, n_compared = 0, cyc = 0, i;
  integer seed = 32'ha58b4903;
  spw_soft_power #(.HALF_SEC_TICKS(4), .DEBOUNCE_TICKS(3), .OVR_HALF_SECS(8)) uut (.*);
  spw_supply_model u_sup (.*);
  // Clock and a hang guard well above the expected run length
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task cmp8(input [7:0] got, input [7:0] exp);
    n_compared++;
    if (got !== exp) begin mismatches++; $display("ERROR %0t: data %h expected %h", $time, got, exp); end
  endtask
  task cmp1(input got, input exp);
    n_compared++;
    if (got !== exp) begin mismatches++; $display("ERROR %0t: flag %b expected %b", $time, got, exp); end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(negedge clk); cfg_addr = a; cfg_wdata = v; cfg_wr = 1'b1;
    @(negedge clk); cfg_wr = 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    @(negedge clk); cfg_addr = a; cfg_rd = 1'b1;
    @(negedge clk); cfg_rd = 1'b0;
    @(negedge clk); cmp8(cfg_rdata, exp);
  endtask
  // Standby ticks spaced so the input synchronisers settle between them
  task ticks(input integer n);
    repeat (n) begin
      @(negedge clk); tick_32k = 1'b1;
      @(negedge clk); tick_32k = 1'b0;
      repeat (6) @(negedge clk);
    end
  endtask
  task pwr(input e);
    repeat (4) @(negedge clk);
    cmp1(supply_on, e);
    cmp1(power_on_n_out, !e);
  endtask
  // Routing outputs from the event level; pm is the expected event
  task route(input pm);
    logic s, l;
    s = pm & sci_route_enable;
    l = sci_active_high ? s : !s;
    cmp1(smi_out, pm & smi_route_enable);
    cmp1(sci_irq_out, s & !sci_to_pin);
    cmp1(sci_pin_out, l);
    cmp1(sci_pin_oe, sci_to_pin & (sci_push_pull | !l));
  endtask
  task press(input integer n);
    button_in = 1'b1; ticks(2); button_in = 1'b0; ticks(n);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(negedge clk); rst_n = 1'b1;
    repeat (4) @(negedge clk);
    rd(8'hb0, 8'h00); rd(8'hb1, 8'h20); rd(8'hf4, 8'h00); rd(8'h55, 8'h00); pwr(0);
    rd(8'hb8, 8'h00); d = $random(seed); wr(8'hb8, d); rd(8'hb8, d);
    wr(8'hb1, 8'ha7); rd(8'hb1, 8'h27); wr(8'hb1, 8'h20);
    {sci_active_high, sci_push_pull} = $random(seed);
    wake_n[0] = 1'b0; ticks(2); pwr(0); rd(8'hb2, 8'h01);
    wake_n[0] = 1'b1; ticks(2); wr(8'hb2, 8'hff); rd(8'hb2, 8'h00);
    for (i = 0; i < 10; i++) begin
      if (i < 8) wr(8'hb0, 8'h01 << i);
      else wr(8'hb1, 8'h20 | (8'h01 << (i - 8)));
      wake_n[i] = 1'b0; ticks(2); pwr(1);
      wake_n[i] = 1'b1; ticks(2);
      rd(i < 8 ? 8'hb2 : 8'hb3, 8'h01 << (i % 8));
      wr(8'hb2, 8'hff); wr(8'hb3, 8'hff);
      d = $random(seed); wr(8'hf4, {1'b1, d[6:5], 5'h00}); pwr(0);
      rd(8'hf4, {1'b0, d[6:5], 5'h00});
    end
    wr(8'hb1, 8'h24); power_button_enable = 1'b1;
    {sci_route_enable, smi_route_enable, sci_to_pin} = $random(seed);
    press(2); pwr(1); cmp1(power_button_status, 1'b1);
    route(1'b1);
    @(negedge clk); power_button_status_clear = 1'b1;
    @(negedge clk); power_button_status_clear = 1'b0; cmp1(power_button_status, 1'b0);
    @(negedge clk); route(1'b0);
    press(2); pwr(1); ticks(3); pwr(0);
    wr(8'hb1, 8'h04); press(2); pwr(1); press(6); pwr(1);
    override_enable = 1'b1; {sci_route_enable, smi_route_enable, sci_to_pin} = $random(seed);
    button_in = 1'b1; ticks(20); button_in = 1'b0; ticks(2); cmp1(override_status, 1'b0); pwr(1);
    button_in = 1'b1; ticks(30); cmp1(override_status, 1'b0);
    ticks(6); cmp1(override_status, 1'b1); cmp1(power_button_status, 1'b0); pwr(0);
    route(1'b1);
    button_in = 1'b0; ticks(6); pwr(0); cmp1(override_status, 1'b1);
    @(negedge clk); override_status_clear = 1'b1;
    @(negedge clk); override_status_clear = 1'b0; cmp1(override_status, 1'b0);
    wr(8'hb3, 8'hff); // Button releases above left the button status bit set
    wr(8'hb1, 8'h40); @(negedge clk); vtr_por = 1'b1; @(negedge clk); vtr_por = 1'b0;
    pwr(1); rd(8'hb3, 8'h08); wr(8'hb3, 8'hff);
    wr(8'hb1, 8'h10); @(negedge clk); vtr_por = 1'b1; @(negedge clk); vtr_por = 1'b0;
    pwr(0); cmp1(power_on_oe, 1'b0);
    rst_n = 1'b0; repeat (3) @(negedge clk); rst_n = 1'b1; repeat (4) @(negedge clk);
    rd(8'hb1, 8'h20); pwr(0);
    stop_test;
  end
endmodule // test_soft_power_wake_override
`default_nettype wire
